// ===== core/adcc_consts.svh
// register map, field positions, reset values and timing counts
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH
`define ADCC_REG_SC1 8'h00
`define ADCC_REG_SC2 8'h01
`define ADCC_REG_IRQ_STAT 8'h02
`define ADCC_REG_IRQ_MASK 8'h03
`define ADCC_SC1_CONVERSION_DONE_FLAG 7
`define ADCC_SC1_DONE_IRQ_ENABLE 6
`define ADCC_SC1_CONTINUOUS_ENABLE 5
`define ADCC_SC2_ACTIVE 7
`define ADCC_SC2_TRIG 6
`define ADCC_SC2_CMP 5
`define ADCC_SC1_RESET 8'h1f
`define ADCC_CH_LAST_INPUT 5'h1b
`define ADCC_CH_RESERVED 5'h1c
`define ADCC_CH_REF_HIGH 5'h1d
`define ADCC_CH_REF_LOW 5'h1e
`define ADCC_CH_OFF 5'h1f
`define ADCC_IRQ_DONE 0
`define ADCC_IRQ_ABORT 1
`define ADCC_IRQ_RESET 2'h0
`define ADCC_CLK_PERIOD_NS 50
`define ADCC_CONV_TIME_NS 1000
`define ADCC_CONV_CYCLES ((`ADCC_CONV_TIME_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)
`endif

// ===== core/adcc_conversion_control.sv
// conversion start, abort, done flag and interrupt control
//
// What this block does
// - any control-one write aborts a running conversion and starts anew unless channel off or hardware trigger selected
// - done flag bit 7 is read only; set at each conversion end without compare
// - with compare enabled the done flag sets only when compare is true
// - done flag clears on control-one write and on low result read
// - bit 6 lets the done flag raise the conversion-complete interrupt
// - continuous bit 5 low: one conversion per write or per hardware trigger
// - continuous bit high: back-to-back conversions started by write or trigger
// - bits 4 to 0 pick the analog input to sample
// - codes 0 to 27 inputs, 28 reserved, 29 high ref, 30 low ref, 31 off
// - channel all ones powers the converter down and isolates the input
// - writing all ones stops continuous mode with no extra conversion
// - converter drops to low power by itself when activity ends
// - compare-enable input decides when the done flag may set
// - trigger-select picks register write or hardware trigger as start source
// - conversion-active sets at start, clears on completion or abort
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_consts.svh"
module adcc_conversion_control #(
    parameter int CONV_CYCLES = `ADCC_CONV_CYCLES
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic compare_enable,
    input wire logic trigger_select,
    input wire logic compare_true,
    input wire logic result_low_read,
    input wire logic hardware_trigger_in,
    output logic [4:0] channel_select,
    output logic converter_power_on,
    output logic input_isolate,
    output logic sel_ref_high,
    output logic sel_ref_low,
    output logic sel_reserved,
    output logic conversion_active,
    output logic irq
);
    adcc_pkg::adcc_ctrl_t r;
    adcc_pkg::adcc_ctrl_t next_r;
    adcc_sar_if sar ();

    logic wr_sc1;
    logic wr_mask;
    logic rd_stat;
    logic wr_off;
    logic ch_off;
    logic trig_edge;
    logic hw_start;
    logic sw_start;
    logic sets_conversion_done_flag;

    ////////////////////////////////////////////////////////////////////////////
    // conversion timer
    adcc_sar_seq #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_seq (
        .core_clk(core_clk),
        .resetn(resetn),
        .sar(sar.seq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode
    assign wr_sc1 = reg_wr && (reg_addr == `ADCC_REG_SC1);
    assign wr_mask = reg_wr && (reg_addr == `ADCC_REG_IRQ_MASK);
    assign rd_stat = reg_rd && (reg_addr == `ADCC_REG_IRQ_STAT);
    assign wr_off = (reg_wdata[4:0] == `ADCC_CH_OFF);
    assign ch_off = (r.ch == `ADCC_CH_OFF);
    // only the second stage of the synchroniser is examined
    assign trig_edge = r.trig_s2 && !r.trig_prev;
    // a trigger edge landing while a conversion is still busy, even on its last cycle, is dropped
    assign hw_start = trig_edge && trigger_select && !ch_off
                      && (!sar.busy || sar.done) && !wr_sc1;
    assign sw_start = wr_sc1 && !wr_off && !trigger_select;
    assign sets_conversion_done_flag = sar.done && (!compare_enable || compare_true);

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_r = r;
        sar.start = 1'b0;
        sar.abort = 1'b0;
        next_r.trig_s1 = hardware_trigger_in;
        next_r.trig_s2 = r.trig_s1;
        next_r.trig_prev = r.trig_s2;

        // register read, data valid in the following cycle only
        next_r.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `ADCC_REG_SC1: next_r.rdata = {r.conversion_done_flag, r.done_irq_enable, r.continuous_enable, r.ch};
                `ADCC_REG_SC2: next_r.rdata = {sar.busy, trigger_select,
                                               compare_enable, 5'h00};
                `ADCC_REG_IRQ_STAT: next_r.rdata = {6'h00, r.irq_stat};
                `ADCC_REG_IRQ_MASK: next_r.rdata = {6'h00, r.irq_mask};
                default: next_r.rdata = 8'h00;
            endcase
        end

        // clears first, so a same-cycle set below wins
        if (rd_stat) begin
            next_r.irq_stat = `ADCC_IRQ_RESET;
        end
        if (wr_mask) begin
            next_r.irq_mask = reg_wdata[1:0];
        end
        if (result_low_read) begin
            next_r.conversion_done_flag = 1'b0;
        end

        if (wr_sc1) begin
            next_r.done_irq_enable = reg_wdata[`ADCC_SC1_DONE_IRQ_ENABLE];
            next_r.continuous_enable = reg_wdata[`ADCC_SC1_CONTINUOUS_ENABLE];
            next_r.ch = reg_wdata[4:0];
            next_r.conversion_done_flag = 1'b0;
            if (sar.busy && !sar.done) begin
                sar.abort = 1'b1;
                next_r.irq_stat[`ADCC_IRQ_ABORT] = 1'b1;
            end
            if (sw_start) begin
                sar.start = 1'b1;
                next_r.mode = reg_wdata[`ADCC_SC1_CONTINUOUS_ENABLE] ? adcc_pkg::ADCC_CONT
                                                        : adcc_pkg::ADCC_SINGLE;
            end else begin
                // off code or hardware mode: stop and wait, no extra conversion
                next_r.mode = adcc_pkg::ADCC_IDLE;
            end
        end else if (hw_start) begin
            sar.start = 1'b1;
            next_r.mode = r.continuous_enable ? adcc_pkg::ADCC_CONT : adcc_pkg::ADCC_SINGLE;
        end else if (sar.done) begin
            unique case (r.mode)
                adcc_pkg::ADCC_CONT: sar.start = !ch_off;
                adcc_pkg::ADCC_SINGLE: next_r.mode = adcc_pkg::ADCC_IDLE;
                adcc_pkg::ADCC_IDLE: next_r.mode = adcc_pkg::ADCC_IDLE;
                default: next_r.mode = adcc_pkg::ADCC_IDLE;
            endcase
        end

        if (sets_conversion_done_flag) begin
            next_r.conversion_done_flag = 1'b1;
            if (!r.conversion_done_flag && r.done_irq_enable) begin
                next_r.irq_stat[`ADCC_IRQ_DONE] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r.mode <= adcc_pkg::ADCC_IDLE;
            r.conversion_done_flag <= 1'b0;
            r.done_irq_enable <= 1'b0;
            r.continuous_enable <= 1'b0;
            r.ch <= `ADCC_CH_OFF;
            r.irq_stat <= `ADCC_IRQ_RESET;
            r.irq_mask <= `ADCC_IRQ_RESET;
            r.rdata <= 8'h00;
            r.trig_s1 <= 1'b0;
            r.trig_s2 <= 1'b0;
            r.trig_prev <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata = r.rdata;
    assign channel_select = r.ch;
    assign converter_power_on = sar.busy;
    assign input_isolate = ch_off;
    assign sel_ref_high = (r.ch == `ADCC_CH_REF_HIGH);
    assign sel_ref_low = (r.ch == `ADCC_CH_REF_LOW);
    assign sel_reserved = (r.ch == `ADCC_CH_RESERVED);
    assign conversion_active = sar.busy;
    assign irq = |(r.irq_stat & r.irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_sw_write_on;
        wr_sc1 && !wr_off && !trigger_select;
    endsequence

    sequence s_started;
        conversion_active && !converter_power_on == 1'b0;
    endsequence

    property p_write_restarts;
        s_sw_write_on |=> s_started;
    endproperty
    a_write_restarts: assert property (p_write_restarts)
        else $error("write did not start a conversion");

    property p_off_write_stops;
        wr_sc1 && wr_off |=> (!conversion_active && !converter_power_on) [*2];
    endproperty
    a_off_write_stops: assert property (p_off_write_stops)
        else $error("off code left the converter running");

    property p_done_plain;
        sar.done && !compare_enable |=> r.conversion_done_flag;
    endproperty
    a_done_plain: assert property (p_done_plain)
        else $error("done flag missed a plain conversion end");

    property p_done_compare_false;
        !r.conversion_done_flag && sar.done && compare_enable && !compare_true |=> !r.conversion_done_flag;
    endproperty
    a_done_compare_false: assert property (p_done_compare_false)
        else $error("done flag set on a false compare");

    property p_flag_clear;
        (wr_sc1 || result_low_read) && !sar.done |=> !r.conversion_done_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("done flag survived its clear");

    property p_done_irq;
        $rose(r.conversion_done_flag) && $past(r.done_irq_enable) && r.irq_mask[`ADCC_IRQ_DONE] |-> irq;
    endproperty
    a_done_irq: assert property (p_done_irq)
        else $error("done interrupt not raised");

    property p_no_irq_disabled;
        !r.done_irq_enable && !r.conversion_done_flag && r.irq_stat == 2'h0 && !wr_sc1 && !sar.busy
            |=> r.irq_stat[`ADCC_IRQ_DONE] == 1'b0;
    endproperty
    a_no_irq_disabled: assert property (p_no_irq_disabled)
        else $error("done interrupt set while disabled");

    property p_single_stops;
        sar.done && r.mode == adcc_pkg::ADCC_SINGLE && !wr_sc1 && !hw_start
            |=> !conversion_active [*3];
    endproperty
    a_single_stops: assert property (p_single_stops)
        else $error("single mode kept converting");

    property p_continuous;
        sar.done && r.mode == adcc_pkg::ADCC_CONT && !wr_sc1 && !ch_off
            |=> conversion_active;
    endproperty
    a_continuous: assert property (p_continuous)
        else $error("continuous mode did not restart");

    property p_off_isolates;
        ch_off |-> input_isolate && !sel_ref_high && !sel_ref_low;
    endproperty
    a_off_isolates: assert property (p_off_isolates)
        else $error("off code did not isolate the input");

    property p_hw_edge_start;
        trig_edge && trigger_select && !ch_off && !sar.busy && !wr_sc1
            |=> conversion_active;
    endproperty
    a_hw_edge_start: assert property (p_hw_edge_start)
        else $error("hardware trigger edge did not start");

    property p_hw_level_once;
        trigger_select && r.trig_s2 && r.trig_prev && !sar.busy && !wr_sc1
            && r.mode != adcc_pkg::ADCC_CONT |=> !conversion_active;
    endproperty
    a_hw_level_once: assert property (p_hw_level_once)
        else $error("held trigger started another conversion");

    property p_abort_clears_active;
        wr_sc1 && (wr_off || trigger_select) |=> !conversion_active;
    endproperty
    a_abort_clears_active: assert property (p_abort_clears_active)
        else $error("abort left conversion active");
endmodule : adcc_conversion_control
`default_nettype wire

// ===== core/adcc_pkg.sv
// types shared by the conversion control and its sequencer
package adcc_pkg;
    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b00,
        ADCC_SINGLE = 2'b01,
        ADCC_CONT = 2'b10
    } adcc_mode_t;

    typedef struct packed {
        adcc_mode_t mode;
        logic conversion_done_flag;
        logic done_irq_enable;
        logic continuous_enable;
        logic [4:0] ch;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [7:0] rdata;
        logic trig_s1;
        logic trig_s2;
        logic trig_prev;
    } adcc_ctrl_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic [15:0] count;
    } adcc_seq_t;
endpackage : adcc_pkg

// ===== core/adcc_sar_if.sv
// start/abort/busy/done carrier between control and sequencer
`timescale 1ns/100ps
`default_nettype none
interface adcc_sar_if;
    logic start;
    logic abort;
    logic busy;
    logic done;
    modport ctrl (output start, output abort, input busy, input done);
    modport seq (input start, input abort, output busy, output done);
endinterface : adcc_sar_if
`default_nettype wire

// ===== core/adcc_sar_seq.sv
// conversion timing sequencer
`timescale 1ns/100ps
`default_nettype none
`include "adcc_consts.svh"
module adcc_sar_seq #(
    parameter int CONV_CYCLES = `ADCC_CONV_CYCLES
) (
    input wire logic core_clk,
    input wire logic resetn,
    adcc_sar_if.seq sar
);
    adcc_pkg::adcc_seq_t r;
    adcc_pkg::adcc_seq_t next_r;

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        if (sar.start) begin
            next_r.busy = 1'b1;
            next_r.count = '0;
        end else if (sar.abort) begin
            next_r.busy = 1'b0;
        end else if (r.busy) begin
            if (r.count == 16'(CONV_CYCLES - 1)) begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end else begin
                next_r.count = r.count + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sar.busy = r.busy;
    assign sar.done = r.done;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_full_run;
        (sar.busy && !sar.abort && !sar.start) [*4];
    endsequence

    property p_seq_done_cause;
        @(posedge core_clk) disable iff (!resetn)
        sar.done |-> $past(r.busy) && $past(r.count) == 16'(CONV_CYCLES - 1);
    endproperty
    a_seq_done_cause: assert property (p_seq_done_cause)
        else $error("done without a full conversion");

    property p_seq_no_early_done;
        @(posedge core_clk) disable iff (!resetn)
        sar.start ##1 s_full_run |-> !sar.done;
    endproperty
    a_seq_no_early_done: assert property (p_seq_no_early_done)
        else $error("conversion ended too early");
endmodule : adcc_sar_seq
`default_nettype wire

// ===== dv/adcc_trig_src.sv
// hardware trigger source model: one held pulse per request
`timescale 1ns/100ps
`default_nettype none
module adcc_trig_src #(
    parameter int HOLD = 12
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic fire,
    output logic hardware_trigger_in
);
    int left;
    // level held well past one conversion, so a level start would show twice
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            left <= 0;
        end else if (fire) begin
            left <= HOLD;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
    assign hardware_trigger_in = (left > 0);
endmodule : adcc_trig_src
`default_nettype wire

// ===== dv/tb_adc_conversion_control.sv
// self-checking bench for the conversion control block
`timescale 1ns/100ps
`default_nettype none
`include "adcc_consts.svh"
module tb_adc_conversion_control;
    localparam int CONV = 4;
    logic core_clk, resetn, reg_wr, reg_rd, compare_enable, trigger_select, compare_true;
    logic result_low_read, hardware_trigger_in, fire, converter_power_on, input_isolate;
    logic sel_ref_high, sel_ref_low, sel_reserved, conversion_active, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [4:0] channel_select;
    int err_total, samples_checked, n;

    adcc_conversion_control #(.CONV_CYCLES(CONV)) uut (.core_clk(core_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .compare_enable(compare_enable),
        .trigger_select(trigger_select), .compare_true(compare_true),
        .result_low_read(result_low_read), .hardware_trigger_in(hardware_trigger_in),
        .channel_select(channel_select), .converter_power_on(converter_power_on),
        .input_isolate(input_isolate), .sel_ref_high(sel_ref_high), .sel_ref_low(sel_ref_low),
        .sel_reserved(sel_reserved), .conversion_active(conversion_active), .irq(irq));
    adcc_trig_src src (.core_clk(core_clk), .resetn(resetn), .fire(fire),
        .hardware_trigger_in(hardware_trigger_in));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    // counts cycles with a conversion running over a fixed span
    task automatic count_active(input int span, output int cnt);
        cnt = 0;
        repeat (span) begin
            #1;
            if (conversion_active === 1'b1) cnt++;
            @(posedge core_clk);
        end
    endtask : count_active

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(`ADCC_REG_SC1, d);
        chk("control one", d, `ADCC_SC1_RESET);
        chk("isolate", {7'h0, input_isolate}, 8'h01);
        rd(8'h10, d);
        chk("unmapped", d, 8'h00);
        $display("reset test done");
    endtask : t_reset

    task automatic t_single;
        wr(`ADCC_REG_IRQ_MASK, 8'h03);
        wr(`ADCC_REG_SC1, 8'hc3);
        count_active(30, n);
        chk("single length", n[7:0], CONV[7:0]);
        rd(`ADCC_REG_SC1, d);
        chk("done flag", d, 8'hc3);
        chk("irq", {7'h0, irq}, 8'h01);
        chk("power", {7'h0, converter_power_on}, 8'h00);
        rd(`ADCC_REG_IRQ_STAT, d);
        chk("status", d, 8'h01);
        chk("irq cleared", {7'h0, irq}, 8'h00);
        @(posedge core_clk);
        result_low_read <= 1'b1;
        @(posedge core_clk);
        result_low_read <= 1'b0;
        rd(`ADCC_REG_SC1, d);
        chk("flag cleared", d, 8'h43);
        $display("single test done");
    endtask : t_single

    task automatic t_compare;
        compare_enable <= 1'b1;
        compare_true <= 1'b0;
        wr(`ADCC_REG_SC1, 8'h82);
        count_active(20, n);
        rd(`ADCC_REG_SC1, d);
        chk("compare false", d, 8'h02);
        compare_true <= 1'b1;
        wr(`ADCC_REG_SC1, 8'h02);
        count_active(20, n);
        rd(`ADCC_REG_SC1, d);
        chk("compare true", d, 8'h82);
        chk("no irq", {7'h0, irq}, 8'h00);
        wr(`ADCC_REG_SC1, 8'h02);
        rd(`ADCC_REG_SC1, d);
        chk("write clears", d, 8'h02);
        count_active(20, n);
        compare_enable <= 1'b0;
        $display("compare test done");
    endtask : t_compare

    task automatic t_abort;
        wr(`ADCC_REG_SC1, 8'h04);
        @(posedge core_clk);
        wr(`ADCC_REG_SC1, 8'h05);
        @(posedge core_clk);
        #1;
        chk("restart", {7'h0, conversion_active}, 8'h01);
        chk("channel", {3'h0, channel_select}, 8'h05);
        rd(`ADCC_REG_IRQ_STAT, d);
        chk("abort event", d, 8'h02);
        count_active(20, n);
        chk("restart length", n[7:0], 8'(CONV - 3));
        $display("abort test done");
    endtask : t_abort

    task automatic t_cont;
        wr(`ADCC_REG_SC1, 8'h26);
        count_active(CONV + 1, n);
        @(posedge core_clk);
        #1;
        chk("back to back", {7'h0, conversion_active}, 8'h01);
        wr(`ADCC_REG_SC1, 8'h1f);
        count_active(20, n);
        chk("stopped", n[7:0], 8'h00);
        chk("power off", {7'h0, converter_power_on}, 8'h00);
        $display("continuous test done");
    endtask : t_cont

    task automatic t_hw;
        trigger_select <= 1'b1;
        wr(`ADCC_REG_SC1, 8'h07);
        count_active(6, n);
        chk("write no start", n[7:0], 8'h00);
        rd(`ADCC_REG_SC2, d);
        chk("control two", d, 8'h40);
        @(posedge core_clk);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        count_active(30, n);
        chk("one per trigger", n[7:0], CONV[7:0]);
        trigger_select <= 1'b0;
        $display("hardware trigger test done");
    endtask : t_hw

    task automatic t_decode;
        logic [4:0] codes [5] = '{5'h1b, 5'h1c, 5'h1d, 5'h1e, 5'h1f};
        logic [7:0] e;
        foreach (codes[i]) begin
            wr(`ADCC_REG_SC1, {3'h0, codes[i]});
            @(posedge core_clk);
            #1;
            e = {4'h0, codes[i] == 5'h1c, codes[i] == 5'h1d, codes[i] == 5'h1e, codes[i] == 5'h1f};
            chk("channel", {3'h0, channel_select}, {3'h0, codes[i]});
            chk("decode", {4'h0, sel_reserved, sel_ref_high, sel_ref_low, input_isolate}, e);
        end
        count_active(20, n);
        chk("off", n[7:0], 8'h00);
        $display("decode test done");
    endtask : t_decode

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        err_total++;
        close_out;
    end

    initial begin
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        compare_enable = 1'b0;
        trigger_select = 1'b0;
        compare_true = 1'b0;
        result_low_read = 1'b0;
        fire = 1'b0;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset;
        t_single;
        t_compare;
        t_abort;
        t_cont;
        t_hw;
        t_decode;
        close_out;
    end
endmodule : tb_adc_conversion_control
`default_nettype wire
